// [shared/byte_op_regs.svh]
// register offsets, field positions, reset values and opcode patterns
`ifndef BYTE_OP_REGS_SVH
`define BYTE_OP_REGS_SVH

`define OFS_CTRL         8'h00
`define OFS_ACC          8'h04
`define OFS_FLAGS        8'h08
`define OFS_BANK         8'h0C
`define OFS_INDEX        8'h10
`define OFS_IRQ_STAT     8'h14
`define OFS_IRQ_CLR      8'h18
`define OFS_IRQ_EN       8'h1C

`define CTRL_EXT_BIT     0
`define FLAGS_PD_BIT     5
`define FLAGS_TO_BIT     6
`define IRQ_SLEEP_BIT    0
`define IRQ_WAKE_BIT     1
`define IRQ_BADOP_BIT    2
`define IRQ_W            3

`define RST_CTRL         1'h0
`define RST_ACC          8'h00
`define RST_FLAGS        5'h00
`define RST_PD           1'h1
`define RST_TO           1'h1
`define RST_BANK         4'h0
`define RST_INDEX        12'h000
`define RST_IRQ          3'h0

`define ACCESS_SPLIT     8'h60
`define INDEX_LIMIT      8'h5F
`define ACCESS_HIGH_BANK 4'hF
`define FILL_VALUE       8'hFF

`define OPC_ROT          6'h10
`define OPC_FILL         7'h34
`define OPC_SLEEP        16'h0003
`define OPC_ACC_MINUS_FILE_BORROW       6'h15
`define OPC_FILE_MINUS_ACC        6'h17
`define OPC_LITERAL_MINUS_ACC        8'h08

`endif

// [shared/byte_op_pkg.sv]
// types shared by the byte-op execution core
package byte_op_pkg;

    typedef enum logic [2:0] {
        OP_NONE,
        OP_ROT,
        OP_FILL,
        OP_SLEEP,
        OP_ACC_MINUS_FILE_BORROW,
        OP_FILE_MINUS_ACC,
        OP_LITERAL_MINUS_ACC
    } op_e;

    // bit 0 carry .. bit 4 negative
    typedef struct packed {
        logic n;
        logic ov;
        logic z;
        logic dc;
        logic c;
    } flags_s;

    typedef struct packed {
        logic [11:0] addr;
        logic        we;
        logic [7:0]  wdata;
    } mem_req_s;

endpackage

// [core/file_addr_resolve.sv]
// file address resolution: access bank, banked and indexed literal offset
`timescale 1ns/1ps
`include "byte_op_regs.svh"

module file_addr_resolve #(
    parameter int BANK_W = 4
) (
    input  wire logic [7:0]          i_f,
    input  wire logic                i_a,
    input  wire logic                i_ext_en,
    input  wire logic [BANK_W-1:0]   i_bank,
    input  wire logic [BANK_W+7:0]   i_index_base,
    output logic      [BANK_W+7:0]   o_addr,
    output logic                     o_indexed
);

    wire             low_half;
    wire [BANK_W+7:0] idx_addr;
    wire [BANK_W+7:0] acc_addr;
    wire [BANK_W+7:0] bank_addr;

    assign low_half  = (i_f < `ACCESS_SPLIT);
    assign o_indexed = i_ext_en & ~i_a & (i_f <= `INDEX_LIMIT);
    // wraps inside the data space, no fault on overflow
    assign idx_addr  = i_index_base + {{BANK_W{1'b0}}, i_f};
    assign acc_addr  = low_half ? {{BANK_W{1'b0}}, i_f}
                                : {{(BANK_W-4){1'b1}}, `ACCESS_HIGH_BANK, i_f};
    assign bank_addr = {i_bank, i_f};
    assign o_addr    = o_indexed ? idx_addr : (i_a ? bank_addr : acc_addr);

endmodule

// [core/sub_rot_alu.sv]
// result and flag logic for rotate, fill and the subtract family
`timescale 1ns/1ps
`include "byte_op_regs.svh"

module sub_rot_alu (
    input  wire byte_op_pkg::op_e    i_op,
    input  wire logic [7:0]          i_acc,
    input  wire logic [7:0]          i_file,
    input  wire logic [7:0]          i_lit,
    input  wire logic                i_carry,
    output logic      [7:0]          o_result,
    output byte_op_pkg::flags_s      o_flags,
    output byte_op_pkg::flags_s      o_mask
);

    logic [7:0] x;
    logic [7:0] y;
    logic       cin;
    wire  [8:0] sum9;
    wire  [4:0] sum5;
    wire  [7:0] diff;
    wire  [7:0] rot;
    wire        is_sub;

    always_comb
    begin
        x   = i_acc;
        y   = i_file;
        cin = 1'b1;
        case (i_op)
            byte_op_pkg::OP_ACC_MINUS_FILE_BORROW:
            begin
                cin = i_carry;
            end
            byte_op_pkg::OP_FILE_MINUS_ACC:
            begin
                x = i_file;
                y = i_acc;
            end
            byte_op_pkg::OP_LITERAL_MINUS_ACC:
            begin
                x = i_lit;
                y = i_acc;
            end
            default:
            begin
                cin = 1'b1;
            end
        endcase
    end

    // two's complement: x + ~y + cin, carry out means no borrow
    assign sum9   = {1'b0, x} + {1'b0, ~y} + {8'h00, cin};
    assign sum5   = {1'b0, x[3:0]} + {1'b0, ~y[3:0]} + {4'h0, cin};
    assign diff   = sum9[7:0];
    assign rot    = {i_file[0], i_file[7:1]};
    assign is_sub = (i_op == byte_op_pkg::OP_ACC_MINUS_FILE_BORROW) | (i_op == byte_op_pkg::OP_FILE_MINUS_ACC)
                  | (i_op == byte_op_pkg::OP_LITERAL_MINUS_ACC);

    always_comb
    begin
        o_result = 8'h00;
        o_flags  = '0;
        o_mask   = '0;
        case (i_op)
            byte_op_pkg::OP_ROT:
            begin
                o_result  = rot;
                o_flags.n = rot[7];
                o_flags.z = (rot == 8'h00);
                o_mask.n  = 1'b1;
                o_mask.z  = 1'b1;
            end
            byte_op_pkg::OP_FILL:
            begin
                o_result = `FILL_VALUE;
            end
            default:
            begin
                if (is_sub)
                begin
                    o_result   = diff;
                    o_flags.n  = diff[7];
                    o_flags.z  = (diff == 8'h00);
                    o_flags.c  = sum9[8];
                    o_flags.dc = sum5[4];
                    o_flags.ov = (x[7] != y[7]) & (diff[7] != x[7]);
                    o_mask     = 5'h1F;
                end
            end
        endcase
    end

endmodule

// [core/byte_op_sleep_exec.sv]
// four-quarter decode/execute core for rotate, fill, sleep and subtract ops
`timescale 1ns/1ps
`include "byte_op_regs.svh"

module byte_op_sleep_exec #(
    parameter int BANK_W = 4
) (
    input  wire logic                i_clk,
    input  wire logic                i_nrst,
    input  wire logic                i_ce,
    input  wire logic                i_psel,
    input  wire logic                i_penable,
    input  wire logic                i_pwrite,
    input  wire logic [7:0]          i_paddr,
    input  wire logic [31:0]         i_pwdata,
    output logic      [31:0]         o_prdata,
    output logic                     o_pready,
    output logic                     o_pslverr,
    input  wire logic                i_instr_valid,
    input  wire logic [15:0]         i_instr,
    output logic                     o_instr_ready,
    output byte_op_pkg::mem_req_s    o_mem,
    input  wire logic [7:0]          i_mem_rdata,
    input  wire logic                i_wake,
    input  wire logic                i_wake_watchdog,
    output logic                     o_sleep,
    output logic                     o_osc_en,
    output logic                     o_watchdog_clear,
    output logic                     o_irq
);

    generate
        if (BANK_W != 4)
        begin : g_bad_bank
            $error("BANK_W must be 4 to fit the 12-bit data address");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // decode helpers

    function automatic byte_op_pkg::op_e decode_op(input logic [15:0] w);
        byte_op_pkg::op_e r;
        r = byte_op_pkg::OP_NONE;
        if (w[15:10] == `OPC_ROT)
            r = byte_op_pkg::OP_ROT;
        else if (w[15:9] == `OPC_FILL)
            r = byte_op_pkg::OP_FILL;
        else if (w == `OPC_SLEEP)
            r = byte_op_pkg::OP_SLEEP;
        else if (w[15:10] == `OPC_ACC_MINUS_FILE_BORROW)
            r = byte_op_pkg::OP_ACC_MINUS_FILE_BORROW;
        else if (w[15:10] == `OPC_FILE_MINUS_ACC)
            r = byte_op_pkg::OP_FILE_MINUS_ACC;
        else if (w[15:8] == `OPC_LITERAL_MINUS_ACC)
            r = byte_op_pkg::OP_LITERAL_MINUS_ACC;
        return r;
    endfunction

    function automatic logic is_mapped(input logic [7:0] a);
        return (a == `OFS_CTRL) | (a == `OFS_ACC) | (a == `OFS_FLAGS) | (a == `OFS_BANK)
             | (a == `OFS_INDEX) | (a == `OFS_IRQ_STAT) | (a == `OFS_IRQ_CLR)
             | (a == `OFS_IRQ_EN);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef enum logic [2:0] {
        ST_Q1,
        ST_Q2,
        ST_Q3,
        ST_Q4,
        ST_SLEEP
    } phase_e;

    phase_e                state_q;
    phase_e                state_d;
    byte_op_pkg::op_e      op_q;
    logic [15:0]           instr_q;
    logic [7:0]            file_q;
    logic [7:0]            acc_q;
    byte_op_pkg::flags_s   flags_q;
    logic                  pd_q;
    logic                  to_q;
    logic                  ext_en_q;
    logic [BANK_W-1:0]     bank_q;
    logic [BANK_W+7:0]     index_q;
    logic [`IRQ_W-1:0]     irq_stat_q;
    logic [`IRQ_W-1:0]     irq_en_q;
    logic [31:0]           prdata_q;
    byte_op_pkg::mem_req_s mem_q;
    logic                  wdt_clr_q;

    wire                   take;
    wire                   wake_now;
    wire                   last_q;
    wire                   dest_file;
    wire                   to_file;
    wire                   to_acc;
    wire [BANK_W+7:0]      res_addr;
    wire [7:0]             alu_res;
    byte_op_pkg::flags_s   alu_flags;
    byte_op_pkg::flags_s   alu_mask;
    byte_op_pkg::flags_s   flags_d;
    byte_op_pkg::op_e      new_op;

    ////////////////////////////////////////////////////////////////////////////////
    // quarter sequencer

    assign new_op   = decode_op(i_instr);
    assign take     = (state_q == ST_Q1) & i_instr_valid;
    assign wake_now = (state_q == ST_SLEEP) & i_wake;
    assign last_q   = (state_q == ST_Q4);
    assign o_instr_ready = (state_q == ST_Q1);

    always_comb
    begin
        state_d = state_q;
        case (state_q)
            ST_Q1:    state_d = i_instr_valid ? ST_Q2 : ST_Q1;
            ST_Q2:    state_d = ST_Q3;
            ST_Q3:    state_d = ST_Q4;
            ST_Q4:    state_d = (op_q == byte_op_pkg::OP_SLEEP) ? ST_SLEEP : ST_Q1;
            ST_SLEEP: state_d = i_wake ? ST_Q1 : ST_SLEEP;
            default:  state_d = ST_Q1;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            state_q <= ST_Q1;
        else if (i_ce)
            state_q <= state_d;
    end

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            op_q    <= byte_op_pkg::OP_NONE;
            instr_q <= 16'h0000;
        end
        else if (i_ce && take)
        begin
            op_q    <= new_op;
            instr_q <= i_instr;
        end
    end

    file_addr_resolve #(
        .BANK_W       (BANK_W)
    ) u_addr (
        .i_f          (i_instr[7:0]),
        .i_a          (i_instr[8]),
        .i_ext_en     (ext_en_q),
        .i_bank       (bank_q),
        .i_index_base (index_q),
        .o_addr       (res_addr),
        .o_indexed    ()
    );

    // operand read at the end of q2
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            file_q <= 8'h00;
        else if (i_ce && state_q == ST_Q2)
            file_q <= i_mem_rdata;
    end

    sub_rot_alu u_alu (
        .i_op         (op_q),
        .i_acc        (acc_q),
        .i_file       (file_q),
        .i_lit        (instr_q[7:0]),
        .i_carry      (flags_q.c),
        .o_result     (alu_res),
        .o_flags      (alu_flags),
        .o_mask       (alu_mask)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // destination select

    assign dest_file = instr_q[9];
    assign to_file = (op_q == byte_op_pkg::OP_FILL)
                   | (dest_file & ((op_q == byte_op_pkg::OP_ROT)
                   | (op_q == byte_op_pkg::OP_ACC_MINUS_FILE_BORROW) | (op_q == byte_op_pkg::OP_FILE_MINUS_ACC)));
    assign to_acc  = (op_q == byte_op_pkg::OP_LITERAL_MINUS_ACC)
                   | (~dest_file & ((op_q == byte_op_pkg::OP_ROT)
                   | (op_q == byte_op_pkg::OP_ACC_MINUS_FILE_BORROW) | (op_q == byte_op_pkg::OP_FILE_MINUS_ACC)));

    // address held from q2, write strobe only during q4
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            mem_q <= '0;
        else if (i_ce)
        begin
            if (take)
                mem_q.addr <= res_addr;
            mem_q.we <= (state_q == ST_Q3) & to_file;
            if (state_q == ST_Q3)
                mem_q.wdata <= alu_res;
        end
    end
    assign o_mem = mem_q;

    ////////////////////////////////////////////////////////////////////////////////
    // apb slave, zero wait states

    wire        setup    = i_psel & ~i_penable;
    wire        access   = i_psel & i_penable;
    wire        mapped   = is_mapped(i_paddr);
    wire        wr       = access & i_pwrite & mapped;
    wire        wr_ctrl  = wr & (i_paddr == `OFS_CTRL);
    wire        wr_acc   = wr & (i_paddr == `OFS_ACC);
    wire        wr_flags = wr & (i_paddr == `OFS_FLAGS);
    wire        wr_bank  = wr & (i_paddr == `OFS_BANK);
    wire        wr_index = wr & (i_paddr == `OFS_INDEX);
    wire        wr_clr   = wr & (i_paddr == `OFS_IRQ_CLR);
    wire        wr_en    = wr & (i_paddr == `OFS_IRQ_EN);
    wire [31:0] rd_mux;

    assign rd_mux =
        (i_paddr == `OFS_CTRL)     ? {31'h0, ext_en_q} :
        (i_paddr == `OFS_ACC)      ? {24'h0, acc_q} :
        (i_paddr == `OFS_FLAGS)    ? {25'h0, to_q, pd_q, flags_q} :
        (i_paddr == `OFS_BANK)     ? {28'h0, bank_q} :
        (i_paddr == `OFS_INDEX)    ? {20'h0, index_q} :
        (i_paddr == `OFS_IRQ_STAT) ? {29'h0, irq_stat_q} :
        (i_paddr == `OFS_IRQ_EN)   ? {29'h0, irq_en_q} : 32'h0000_0000;

    // read data latched in setup so it comes from a flop
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            prdata_q <= 32'h0000_0000;
        else if (i_ce && setup)
            prdata_q <= rd_mux;
    end
    assign o_prdata  = prdata_q;
    assign o_pready  = 1'b1;
    assign o_pslverr = access & ~mapped;

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            ext_en_q <= `RST_CTRL;
            bank_q   <= `RST_BANK;
            index_q  <= `RST_INDEX;
            irq_en_q <= `RST_IRQ;
        end
        else if (i_ce)
        begin
            if (wr_ctrl)
                ext_en_q <= i_pwdata[`CTRL_EXT_BIT];
            if (wr_bank)
                bank_q <= i_pwdata[BANK_W-1:0];
            if (wr_index)
                index_q <= i_pwdata[BANK_W+7:0];
            if (wr_en)
                irq_en_q <= i_pwdata[`IRQ_W-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // accumulator and flags, q4 commit beats a bus write

    assign flags_d = (flags_q & ~alu_mask) | (alu_flags & alu_mask);

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            acc_q   <= `RST_ACC;
            flags_q <= `RST_FLAGS;
        end
        else if (i_ce)
        begin
            if (last_q && to_acc)
                acc_q <= alu_res;
            else if (wr_acc)
                acc_q <= i_pwdata[7:0];
            if (last_q)
                flags_q <= flags_d;
            else if (wr_flags)
                flags_q <= i_pwdata[4:0];
        end
    end

    // power status: read-only to software
    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
        begin
            pd_q <= `RST_PD;
            to_q <= `RST_TO;
        end
        else if (i_ce)
        begin
            if (last_q && op_q == byte_op_pkg::OP_SLEEP)
            begin
                pd_q <= 1'b0;
                to_q <= 1'b1;
            end
            else if (wake_now && i_wake_watchdog)
                to_q <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // sleep and watchdog outputs

    always_ff @(posedge i_clk or negedge i_nrst)
    begin
        if (!i_nrst)
            wdt_clr_q <= 1'b0;
        else if (i_ce)
            wdt_clr_q <= last_q & (op_q == byte_op_pkg::OP_SLEEP);
    end
    assign o_watchdog_clear = wdt_clr_q;
    assign o_sleep  = (state_q == ST_SLEEP);
    assign o_osc_en = (state_q != ST_SLEEP);

    ////////////////////////////////////////////////////////////////////////////////
    // interrupt status: set beats clear

    wire [`IRQ_W-1:0] irq_set;
    assign irq_set[`IRQ_SLEEP_BIT] = last_q & (op_q == byte_op_pkg::OP_SLEEP);
    assign irq_set[`IRQ_WAKE_BIT]  = wake_now;
    assign irq_set[`IRQ_BADOP_BIT] = last_q & (op_q == byte_op_pkg::OP_NONE);

    genvar gi;
    generate
        for (gi = 0; gi < `IRQ_W; gi++)
        begin : g_irq
            always_ff @(posedge i_clk or negedge i_nrst)
            begin
                if (!i_nrst)
                    irq_stat_q[gi] <= 1'b0;
                else if (i_ce)
                    irq_stat_q[gi] <= irq_set[gi] | (irq_stat_q[gi] & ~(wr_clr & i_pwdata[gi]));
            end
        end
    endgenerate

    assign o_irq = |(irq_stat_q & irq_en_q);

endmodule

// [tb/byte_op_sleep_exec_assertions.sv]
// port-level checks for the byte-op execution core
`timescale 1ns/1ps

module byte_op_sleep_exec_assertions (
    input  wire logic                  i_clk,
    input  wire logic                  i_nrst,
    input  wire logic                  i_ce,
    input  wire logic                  i_instr_valid,
    input  wire logic [15:0]           i_instr,
    input  wire logic                  o_instr_ready,
    input  wire byte_op_pkg::mem_req_s o_mem,
    input  wire logic [7:0]            i_mem_rdata,
    input  wire logic                  i_wake,
    input  wire logic                  o_sleep,
    input  wire logic                  o_osc_en,
    input  wire logic                  o_watchdog_clear
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_nrst);

    wire       take  = i_ce && i_instr_valid && o_instr_ready;
    wire       byop  = i_instr[15:12] != 4'h0;
    wire [5:0] op6   = i_instr[15:10];
    wire [7:0] fbyte = i_instr[7:0];

    chk_osc_follows:
        assert property (o_osc_en == !o_sleep) else $error("osc enable wrong");
    chk_wdog_entry:
        assert property ($rose(o_sleep) == o_watchdog_clear) else $error("watchdog clear wrong");
    chk_we_single:
        assert property (o_mem.we |=> !o_mem.we) else $error("write strobe too long");
    chk_instr_spacing:
        assert property (take |=> !o_instr_ready [*3] ##1 (o_instr_ready || o_sleep))
        else $error("instruction spacing wrong");
    chk_dest_select:
        assert property (take && (op6 == 6'h10 || op6 == 6'h15) |-> ##3
            (o_mem.we == $past(i_instr[9], 3))) else $error("destination wrong");
    chk_fill_value:
        assert property (take && i_instr[15:9] == 7'h34 |-> ##3
            (o_mem.we && o_mem.wdata == 8'hFF)) else $error("fill value wrong");
    chk_rot_value:
        assert property (o_mem.we && $past(op6, 3) == 6'h10 |->
            o_mem.wdata == {i_mem_rdata[0], i_mem_rdata[7:1]}) else $error("rotate wrong");
    chk_bank_addr:
        assert property (take && byop && i_instr[8] |=> o_mem.addr[7:0] == $past(fbyte))
        else $error("banked address wrong");
    chk_access_high:
        assert property (take && byop && !i_instr[8] && fbyte >= 8'h60 |=>
            o_mem.addr == {4'hF, $past(fbyte)}) else $error("access bank wrong");
    chk_sleep_entry:
        assert property (take && i_instr == 16'h0003 |-> ##4 $rose(o_sleep))
        else $error("sleep entry late");
    chk_wake_ready:
        assert property (o_sleep && i_wake && i_ce |=> !o_sleep && o_instr_ready)
        else $error("wake not taken");
endmodule

bind byte_op_sleep_exec byte_op_sleep_exec_assertions u_chk (
    .i_clk(i_clk), .i_nrst(i_nrst), .i_ce(i_ce), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .o_instr_ready(o_instr_ready), .o_mem(o_mem),
    .i_mem_rdata(i_mem_rdata), .i_wake(i_wake), .o_sleep(o_sleep),
    .o_osc_en(o_osc_en), .o_watchdog_clear(o_watchdog_clear)
);

// [tb/prog_mem_model.sv]
// program word feed and data file model facing the execution core
`timescale 1ns/1ps

module prog_mem_model (
    input  wire logic                  i_clk,
    input  wire logic                  i_ready,
    input  wire byte_op_pkg::mem_req_s i_mem,
    output logic                       o_valid,
    output logic [15:0]                o_instr,
    output logic [7:0]                 o_rdata
);
    logic [7:0]  mem [4096];
    logic [15:0] q [$];

    initial
    begin
        o_valid = 1'b0;
        o_instr = 16'h0000;
    end
    assign o_rdata = mem[i_mem.addr];
    always @(posedge i_clk)
    begin
        if (o_valid && i_ready)
            void'(q.pop_front());
        o_valid <= q.size() != 0;
        // idle word flips so a stale opcode is never mistaken for a held one
        o_instr <= (q.size() != 0) ? q[0] : ~o_instr;
        if (i_mem.we)
            mem[i_mem.addr] <= i_mem.wdata;
    end
endmodule

// [tb/byte_op_sleep_exec_test.sv]
// self-checking bench for the byte-op execution core
`timescale 1ns/1ps
`include "byte_op_regs.svh"

module byte_op_sleep_exec_test;
    logic                  clk = 1'b0;
    logic                  i_nrst = 1'b0;
    logic                  psel = 1'b0;
    logic                  penable = 1'b0;
    logic                  pwrite = 1'b0;
    logic [7:0]            paddr = 8'h00;
    logic [31:0]           pwdata = 32'h0;
    logic [31:0]           prdata;
    logic                  pready;
    logic                  pslverr;
    logic                  perr;
    logic                  ivalid;
    logic [15:0]           instr;
    logic                  iready;
    byte_op_pkg::mem_req_s mem;
    logic [7:0]            mrdata;
    logic                  wake = 1'b0;
    logic                  wake_wd = 1'b0;
    logic                  ce = 1'b1;
    logic                  sleep;
    logic                  osc_en;
    logic                  wd_clear;
    logic                  irq;
    int                    n_fail = 0;
    int                    tests_run = 0;

    always #10 clk = ~clk;

    byte_op_sleep_exec #(.BANK_W(4)) dut (
        .i_clk(clk), .i_nrst(i_nrst), .i_ce(ce), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_instr_valid(ivalid), .i_instr(instr),
        .o_instr_ready(iready), .o_mem(mem), .i_mem_rdata(mrdata), .i_wake(wake),
        .i_wake_watchdog(wake_wd), .o_sleep(sleep), .o_osc_en(osc_en),
        .o_watchdog_clear(wd_clear), .o_irq(irq)
    );
    prog_mem_model u_mem (
        .i_clk(clk), .i_ready(iready), .i_mem(mem), .o_valid(ivalid), .o_instr(instr),
        .o_rdata(mrdata)
    );

    ////////////////////////////////////////////////////////////////////////////////
    task automatic complete_run(input logic timed_out);
        if (timed_out)
            n_fail++;
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        tests_run++;
        if (got !== exp)
        begin
            n_fail++;
            $display("CHECK FAILED at %0t: %s got %h", $time, m, got);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(negedge clk);
        n = 0;
        while (pready !== 1'b1)
        begin
            n++;
            if (n > 20)
                complete_run(1'b1);
            @(negedge clk);
        end
        r = prdata;
        perr = pslverr;
        @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        apb(1'b1, a, d, r);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e, input string m);
        logic [31:0] r;
        apb(1'b0, a, 32'h0, r);
        chk(r, e, m);
    endtask

    task automatic mchk(input logic [11:0] a, input logic [7:0] e, input string m);
        chk({24'h0, u_mem.mem[a]}, {24'h0, e}, m);
    endtask

    // latency is fixed by the four-quarter cycle, so a fixed wait is safe here
    task automatic run(input logic [15:0] w);
        u_mem.q.push_back(w);
        repeat (8) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd(`OFS_FLAGS, 32'h60, "flags reset");
        rd(`OFS_ACC, 32'h0, "acc reset");
        rd(8'h20, 32'h0, "unmapped read");
        chk({31'h0, perr}, 32'h1, "unmapped error");
        ce <= 1'b0;
        wr(`OFS_ACC, 32'h5);
        ce <= 1'b1;
        rd(`OFS_ACC, 32'h0, "frozen by enable");
        run(16'hFFFF);
        rd(`OFS_IRQ_STAT, 32'h4, "unknown opcode event");
        wr(`OFS_IRQ_CLR, 32'h4);
        $display("reset test done");
    endtask

    task automatic t_rotate();
        wr(`OFS_BANK, 32'h2);
        wr(`OFS_FLAGS, 32'h01);
        u_mem.mem[12'h240] = 8'hD7;
        u_mem.mem[12'h010] = 8'hD7;
        run(16'h4340);
        mchk(12'h240, 8'hEB, "rotate to file");
        rd(`OFS_FLAGS, 32'h71, "rotate flags");
        run(16'h4010);
        rd(`OFS_ACC, 32'hEB, "rotate to acc");
        mchk(12'h010, 8'hD7, "file kept");
        $display("rotate test done");
    endtask

    task automatic t_fill();
        wr(`OFS_FLAGS, 32'h0A);
        u_mem.mem[12'hF80] = 8'h00;
        u_mem.mem[12'h35F] = 8'h00;
        u_mem.mem[12'hF60] = 8'h00;
        run(16'h6880);
        mchk(12'hF80, 8'hFF, "fill access high");
        rd(`OFS_FLAGS, 32'h6A, "fill flags");
        wr(`OFS_CTRL, 32'h1);
        wr(`OFS_INDEX, 32'h300);
        run(16'h685F);
        mchk(12'h35F, 8'hFF, "indexed at limit");
        run(16'h6860);
        mchk(12'hF60, 8'hFF, "just above limit");
        wr(`OFS_CTRL, 32'h0);
        $display("fill test done");
    endtask

    task automatic t_subtract();
        wr(`OFS_ACC, 32'h3);
        wr(`OFS_FLAGS, 32'h1);
        u_mem.mem[12'h240] = 8'h02;
        run(16'h5540);
        rd(`OFS_ACC, 32'h01, "sub borrow to acc");
        rd(`OFS_FLAGS, 32'h63, "sub flags positive");
        wr(`OFS_ACC, 32'h2);
        wr(`OFS_FLAGS, 32'h0);
        run(16'h5740);
        mchk(12'h240, 8'hFF, "sub borrow to file");
        rd(`OFS_FLAGS, 32'h70, "sub flags negative");
        run(16'h5F40);
        mchk(12'h240, 8'hFD, "file minus acc");
        rd(`OFS_FLAGS, 32'h73, "file minus acc flags");
        wr(`OFS_ACC, 32'h3);
        run(16'h0802);
        rd(`OFS_ACC, 32'hFF, "literal minus acc");
        rd(`OFS_FLAGS, 32'h70, "literal flags");
        $display("subtract test done");
    endtask

    task automatic t_sleep();
        int n;
        wr(`OFS_IRQ_EN, 32'h7);
        u_mem.q.push_back(16'h0003);
        n = 0;
        while (sleep !== 1'b1)
        begin
            @(negedge clk);
            n++;
            if (n > 20)
                complete_run(1'b1);
        end
        chk({31'h0, wd_clear}, 32'h1, "watchdog cleared");
        chk({31'h0, osc_en}, 32'h0, "oscillator off");
        rd(`OFS_FLAGS, 32'h50, "sleep status");
        rd(`OFS_IRQ_STAT, 32'h1, "sleep event");
        chk({31'h0, irq}, 32'h1, "irq raised");
        wr(`OFS_IRQ_EN, 32'h0);
        @(negedge clk);
        chk({31'h0, irq}, 32'h0, "irq masked");
        wr(`OFS_IRQ_EN, 32'h7);
        wr(`OFS_IRQ_CLR, 32'h1);
        rd(`OFS_IRQ_STAT, 32'h0, "event cleared");
        @(posedge clk);
        wake <= 1'b1;
        wake_wd <= 1'b1;
        @(posedge clk);
        wake <= 1'b0;
        wake_wd <= 1'b0;
        @(negedge clk);
        chk({31'h0, sleep}, 32'h0, "woken");
        rd(`OFS_FLAGS, 32'h10, "watchdog wake");
        rd(`OFS_IRQ_STAT, 32'h2, "wake event");
        $display("sleep test done");
    endtask

    initial
    begin
        repeat (4) @(posedge clk);
        i_nrst <= 1'b1;
        t_reset();
        t_rotate();
        t_fill();
        t_subtract();
        t_sleep();
        complete_run(1'b0);
    end
endmodule
